// ==== core/dfk_baud_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module dfk_baud_decode (
	input wire logic [6:0] code, // Displayed baud code
	output logic [10:0] kbps, // Rate in kbit/s, 0 when code invalid
	output logic valid // Code is one of the listed values
);
	always_comb
	begin
		valid = 1'b1;
		unique case (code)
			7'h01: kbps = 11'h00A;
			7'h02: kbps = 11'h014;
			7'h05: kbps = 11'h032;
			7'h0A: kbps = 11'h064;
			7'h0C: kbps = 11'h07D;
			7'h19: kbps = 11'h0FA;
			7'h21: kbps = 11'h14D;
			7'h32: kbps = 11'h1F4;
			7'h42: kbps = 11'h29A;
			7'h50: kbps = 11'h320;
			7'h64: kbps = 11'h3E8;
			default:
			begin
				kbps = 11'h000;
				valid = 1'b0;
			end
		endcase
	end
endmodule : dfk_baud_decode
`default_nettype wire

// ==== core/dfk_supervisor.sv ====
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Any fault: show code, open ready, off, brake
// - Heat sink above 80 C raises F01
// - DC bus below 100 V raises F05
// - STO and enable together raise F27
// - Config 16: starred faults cleared by reset only
// - Clear command clears non-starred faults
// - Disabled with STO low shows STO status
// - Two or three missing phases raise F16
// - Escalated warning becomes F24 full fault
// - CAN bus-off raises F23
// - Overspeed raises F08
// - Conversion error raises F17
// - Limit switch error while homing raises F26
// - Single key press steps by one
// - Double press steps by ten
// - Right held then left means enter
// - Right key at power-up selects advanced menu
// - Baud code decodes to kbit/s table
// - Address and baud apply after aux cycle
// - Addresses up to 255, answer own only
// - Jog runs while key held, stops on release
// - Warning shows code, keeps drive running
module dfk_supervisor #(
	parameter int TAP_CYCLES = dfk_pkg::DOUBLE_TAP_CYC // Double-press window
) (
	input wire logic clock, // 20 MHz system clock
	input wire logic nrst, // Sync reset, also the hardware reset of the drive
	input wire logic [7:0] heat_sink_temp, // Heat sink temperature, deg C
	input wire logic [9:0] dc_bus_volts, // DC bus voltage, V
	input wire logic safe_torque_off_enable, // Safe_torque_off_enable input
	input wire logic hw_enable, // Hardware enable input
	input wire logic [2:0] mains_phase_ok, // One bit per mains phase present
	input wire logic warning_active, // Any warning present
	input wire logic [5:0] warning_code, // Coded warning number
	input wire logic escalate_warnings, // Warnings become F24
	input wire logic can_bus_off, // CAN controller bus-off
	input wire logic overspeed, // Speed above limit
	input wire logic adc_error, // Conversion error
	input wire logic homing_active, // Homing move running
	input wire logic limit_switch_error, // Hardware limit switch error
	input wire logic [7:0] drive_config_word_three, // Drive configuration word
	input wire logic clear_fault_command, // Clear request pulse
	input wire logic key_up, // Up (right) key level
	input wire logic key_down, // Down (left) key level
	input wire logic aux_supply_ok, // 24V auxiliary supply present
	input wire logic jog_mode, // Jog mode selected
	input wire logic [7:0] edit_load, // Value loaded into editor
	input wire logic edit_load_strobe, // Load editor pulse
	input wire logic edit_is_baud, // Editor holds baud code
	input wire logic [7:0] cmd_station, // Station of incoming command
	input wire logic cmd_strobe, // Incoming command pulse
	output logic [5:0] display_code, // Code on LED display
	output logic [1:0] display_mode, // What the display shows
	output logic ready_to_operate_contact, // 1 = contact closed
	output logic output_stage_on, // Power stage enabled
	output logic brake_released, // 0 = holding brake engaged
	output logic [5:0] error_code_parameter, // Latched fault code
	output logic advanced_menu, // Advanced menu selected
	output logic menu_step, // One-cycle pulse: next menu item
	output logic [7:0] edit_value, // Number being edited
	output logic edit_enter, // One-cycle pulse: number accepted
	output logic [7:0] station_address, // Active station address
	output logic [10:0] baud_kbps, // Active baud rate
	output logic cmd_accept, // One-cycle pulse: command for us
	output logic jog_run, // Motor jogging at preset speed
	output logic jog_dir_up // Jog direction
);
	typedef enum logic [2:0] {
		DFK_KEY_IDLE = 3'b001,
		DFK_KEY_WAIT = 3'b010,
		DFK_KEY_ENTER = 3'b100
	} dfk_key_e;

	typedef struct packed {
		logic [5:0] code;
		logic starred;
		logic [1:0] dmode;
		logic [5:0] dcode;
		logic rdy;
		logic stage;
		logic brk_rel;
		logic adv;
		logic aux_prev;
		logic sto_prev;
		logic en_prev;
		dfk_key_e kst;
		logic last_up;
		logic up_prev;
		logic dn_prev;
		logic [23:0] tap_cnt;
		logic step;
		logic [7:0] value;
		logic enter;
		logic [7:0] pend_addr;
		logic [6:0] pend_baud;
		logic [7:0] addr;
		logic [10:0] baud;
		logic acc;
		logic jog;
		logic jog_up;
	} dfk_state_s;

	dfk_state_s st_reg, st_next;
	logic [10:0] dec_kbps;
	logic dec_valid;
	logic [5:0] new_code;
	logic fault_now;
	logic cfg_hw_only;
	logic up_rise, dn_rise;
	logic [1:0] lost_cnt;

	// ----------------------------------------
	// Mains phase loss, one flag per phase
	// ----------------------------------------
	wire logic [2:0] phase_lost;
	for (genvar g = 0; g < 3; g++)
	begin : g_phase
		assign phase_lost[g] = !mains_phase_ok[g];
	end

	dfk_baud_decode u_baud (
		.code(st_reg.pend_baud),
		.kbps(dec_kbps),
		.valid(dec_valid)
	);

	// ----------------------------------------
	// Fault detection, lowest code wins
	// ----------------------------------------
	always_comb
	begin
		// Later tests override earlier ones, so the lowest code wins
		new_code = dfk_pkg::FC_NONE;
		lost_cnt = {1'b0, phase_lost[0]} + {1'b0, phase_lost[1]} + {1'b0, phase_lost[2]};
		if (safe_torque_off_enable && hw_enable && !st_reg.sto_prev && !st_reg.en_prev)
			new_code = dfk_pkg::FC_STO_SEQ;
		if (homing_active && limit_switch_error)
			new_code = dfk_pkg::FC_LIMIT;
		if (warning_active && escalate_warnings)
			new_code = dfk_pkg::FC_WARN;
		if (can_bus_off)
			new_code = dfk_pkg::FC_CANOFF;
		if (adc_error)
			new_code = dfk_pkg::FC_ADC;
		if (lost_cnt >= 2'h2)
			new_code = dfk_pkg::FC_PHASES;
		if (overspeed)
			new_code = dfk_pkg::FC_OVERSPEED;
		if (dc_bus_volts < dfk_pkg::UNDERVOLT_LIMIT_V)
			new_code = dfk_pkg::FC_UNDERVOLT;
		if (heat_sink_temp > dfk_pkg::HEAT_LIMIT_C)
			new_code = dfk_pkg::FC_HEAT;
		fault_now = (new_code != dfk_pkg::FC_NONE);
		cfg_hw_only = (drive_config_word_three == dfk_pkg::CFG_HW_RESET_ONLY);
		up_rise = key_up && !st_reg.up_prev;
		dn_rise = key_down && !st_reg.dn_prev;
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		st_next = st_reg;
		// Previous levels for edge detection, reset low like idle pins
		st_next.sto_prev = safe_torque_off_enable;
		st_next.en_prev = hw_enable;
		st_next.up_prev = key_up;
		st_next.dn_prev = key_down;
		st_next.aux_prev = aux_supply_ok;
		st_next.step = 1'b0;
		st_next.enter = 1'b0;
		st_next.acc = 1'b0;

		// Clear first so a fault in the same cycle still latches
		if (clear_fault_command && st_reg.code != dfk_pkg::FC_NONE)
		begin
			if (!(st_reg.starred && cfg_hw_only))
				st_next.code = dfk_pkg::FC_NONE;
		end
		// A code still held is never replaced by a newer fault
		if (fault_now && st_next.code == dfk_pkg::FC_NONE)
		begin
			st_next.code = new_code;
			st_next.starred = dfk_pkg::STARRED_MASK[new_code[4:0]];
		end

		// ----------------------------------------
		// Safe state and display
		// ----------------------------------------
		if (st_next.code != dfk_pkg::FC_NONE)
		begin
			st_next.rdy = 1'b0;
			st_next.stage = 1'b0;
			st_next.brk_rel = 1'b0;
			st_next.dmode = dfk_pkg::DISP_FAULT;
			st_next.dcode = st_next.code;
		end
		else
		begin
			st_next.rdy = 1'b1;
			st_next.stage = hw_enable && safe_torque_off_enable;
			st_next.brk_rel = hw_enable && safe_torque_off_enable;
			if (!hw_enable && !safe_torque_off_enable)
			begin
				st_next.dmode = dfk_pkg::DISP_STO;
				st_next.dcode = dfk_pkg::FC_NONE;
			end
			else if (warning_active)
			begin
				st_next.dmode = dfk_pkg::DISP_WARN;
				st_next.dcode = warning_code;
			end
			else
			begin
				st_next.dmode = dfk_pkg::DISP_IDLE;
				st_next.dcode = dfk_pkg::FC_NONE;
			end
		end

		// ----------------------------------------
		// Menu choice on aux power-up
		// ----------------------------------------
		// Pending settings take effect only here, never while running
		if (aux_supply_ok && !st_reg.aux_prev)
		begin
			st_next.adv = key_up;
			st_next.addr = st_reg.pend_addr;
			if (dec_valid)
				st_next.baud = dec_kbps;
		end

		// ----------------------------------------
		// Keypad
		// ----------------------------------------
		// Counts down the double-press window
		if (st_reg.tap_cnt != 24'h000000)
			st_next.tap_cnt = st_reg.tap_cnt - 24'h000001;
		if (edit_load_strobe)
			st_next.value = edit_load;
		unique case (st_reg.kst)
			DFK_KEY_IDLE:
			begin
				if (key_up && dn_rise)
					st_next.kst = DFK_KEY_ENTER;
				else if (up_rise || dn_rise)
				begin
					st_next.step = up_rise;
					st_next.value = up_rise ? st_reg.value + 8'h01 : st_reg.value - 8'h01;
					st_next.last_up = up_rise;
					st_next.tap_cnt = TAP_CYCLES[23:0];
					st_next.kst = DFK_KEY_WAIT;
				end
			end
			DFK_KEY_WAIT:
			begin
				if (key_up && dn_rise)
				begin
					// The right press already stepped the value; keep it
					st_next.kst = DFK_KEY_ENTER;
				end
				else if ((up_rise && st_reg.last_up) || (dn_rise && !st_reg.last_up))
				begin
					// Undo the first step and apply ten in total
					st_next.value = st_reg.last_up ? st_reg.value + 8'(dfk_pkg::DIGIT_TEN - 4'h1)
						: st_reg.value - 8'(dfk_pkg::DIGIT_TEN - 4'h1);
					st_next.kst = DFK_KEY_IDLE;
				end
				// Window over or the other key: back to single presses
				else if (st_reg.tap_cnt == 24'h000000 || up_rise || dn_rise)
					st_next.kst = DFK_KEY_IDLE;
			end
			DFK_KEY_ENTER:
			begin
				st_next.enter = 1'b1;
				// Accepted number waits as a pending setting
				if (edit_is_baud)
					st_next.pend_baud = st_reg.value[6:0];
				else
					st_next.pend_addr = st_reg.value;
				st_next.kst = DFK_KEY_IDLE;
			end
			default:
				st_next.kst = DFK_KEY_IDLE;
		endcase

		// ----------------------------------------
		// Station filter
		// ----------------------------------------
		// Address 0 is unset and never answers
		if (cmd_strobe && cmd_station == st_reg.addr && st_reg.addr != 8'h00)
			st_next.acc = 1'b1;

		// ----------------------------------------
		// Jog
		// ----------------------------------------
		// Stops the cycle a key is released or a fault latches
		st_next.jog = jog_mode && (key_up ^ key_down) && st_next.code == dfk_pkg::FC_NONE
			&& st_next.stage;
		st_next.jog_up = key_up;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			st_reg <= '0;
			st_reg.kst <= DFK_KEY_IDLE;
			// Power-on station and baud defaults
			st_reg.pend_addr <= dfk_pkg::STATION_RST;
			st_reg.pend_baud <= dfk_pkg::BAUD_CODE_RST;
			st_reg.addr <= dfk_pkg::STATION_RST;
			st_reg.baud <= dfk_pkg::BAUD_KBPS_RST;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign display_code = st_reg.dcode;
	assign display_mode = st_reg.dmode;
	assign ready_to_operate_contact = st_reg.rdy;
	assign output_stage_on = st_reg.stage;
	assign brake_released = st_reg.brk_rel;
	assign error_code_parameter = st_reg.code;
	assign advanced_menu = st_reg.adv;
	assign menu_step = st_reg.step;
	assign edit_value = st_reg.value;
	assign edit_enter = st_reg.enter;
	assign station_address = st_reg.addr;
	assign baud_kbps = st_reg.baud;
	assign cmd_accept = st_reg.acc;
	assign jog_run = st_reg.jog;
	assign jog_dir_up = st_reg.jog_up;
endmodule : dfk_supervisor
`default_nettype wire

// ==== inc/dfk_pkg.sv ====
package dfk_pkg;
	// ----------------------------------------
	// Fault codes shown on the display
	// ----------------------------------------
	localparam logic [5:0] FC_NONE = 6'h00;
	localparam logic [5:0] FC_HEAT = 6'h01;
	localparam logic [5:0] FC_UNDERVOLT = 6'h05;
	localparam logic [5:0] FC_OVERSPEED = 6'h08;
	localparam logic [5:0] FC_PHASES = 6'h10;
	localparam logic [5:0] FC_ADC = 6'h11;
	localparam logic [5:0] FC_CANOFF = 6'h17;
	localparam logic [5:0] FC_WARN = 6'h18;
	localparam logic [5:0] FC_LIMIT = 6'h1A;
	localparam logic [5:0] FC_STO_SEQ = 6'h1B;
	// Display modes
	localparam logic [1:0] DISP_IDLE = 2'h0;
	localparam logic [1:0] DISP_FAULT = 2'h1;
	localparam logic [1:0] DISP_WARN = 2'h2;
	localparam logic [1:0] DISP_STO = 2'h3;
	// Thresholds and configuration
	localparam logic [7:0] HEAT_LIMIT_C = 8'h50;
	localparam logic [9:0] UNDERVOLT_LIMIT_V = 10'h064;
	localparam logic [7:0] CFG_HW_RESET_ONLY = 8'h10;
	// Starred-fault mask, bit n set when code n is hardware-reset only
	localparam logic [31:0] STARRED_MASK = 32'h0AB64B90;
	// Power-on station and baud defaults
	localparam logic [7:0] STATION_RST = 8'h01;
	localparam logic [6:0] BAUD_CODE_RST = 7'h64;
	localparam logic [10:0] BAUD_KBPS_RST = 11'h3E8;
	// Timing
	localparam int CLK_HZ = 20000000;
	localparam int DOUBLE_TAP_MS = 300;
	localparam int DOUBLE_TAP_CYC = CLK_HZ / 1000 * DOUBLE_TAP_MS;
	localparam logic [3:0] DIGIT_TEN = 4'hA;
endpackage : dfk_pkg

// ==== verification/dfk_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module dfk_assertions (
	input wire logic clock, // Clock
	input wire logic nrst, // Reset
	input wire logic [7:0] heat_sink_temp, // Temp
	input wire logic [9:0] dc_bus_volts, // Bus
	input wire logic overspeed, // Speed
	input wire logic [7:0] drive_config_word_three, // Config
	input wire logic clear_fault_command, // Clear
	input wire logic key_up, // Right
	input wire logic key_down, // Left
	input wire logic aux_supply_ok, // Aux
	input wire logic [7:0] cmd_station, // Station
	input wire logic cmd_strobe, // Strobe
	input wire logic [1:0] display_mode, // Mode
	input wire logic ready_to_operate_contact, // Ready
	input wire logic output_stage_on, // Stage
	input wire logic brake_released, // Brake
	input wire logic [5:0] error_code_parameter, // Code
	input wire logic advanced_menu, // Menu
	input wire logic edit_enter, // Enter
	input wire logic [7:0] station_address, // Address
	input wire logic cmd_accept // Accept
);
	// ----------------
	// Helpers
	// ----------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	logic calm;
	logic hit_q;
	assign calm = heat_sink_temp <= dfk_pkg::HEAT_LIMIT_C && dc_bus_volts >= 10'h064;
	always_ff @(posedge clock)
	begin
		hit_q <= cmd_strobe && cmd_station == station_address && station_address != 8'h00;
	end
	sequence s_chord;
		key_up && $rose(key_down);
	endsequence
	sequence s_aux_up;
		$rose(aux_supply_ok);
	endsequence
	// ----------------
	// Checks
	// ----------------
	AST_FAULT_SAFE: assert property (
		!calm |=> display_mode == dfk_pkg::DISP_FAULT && !ready_to_operate_contact
			&& !output_stage_on && !brake_released)
		else $error("Fault did not force the safe state");
	AST_HEAT_CODE: assert property (
		heat_sink_temp > dfk_pkg::HEAT_LIMIT_C |=> error_code_parameter == dfk_pkg::FC_HEAT)
		else $error("Heat fault code wrong");
	AST_UNDERVOLT_CODE: assert property (
		dc_bus_volts < 10'h064 && heat_sink_temp <= dfk_pkg::HEAT_LIMIT_C
			&& error_code_parameter == 6'h00 |=> error_code_parameter == dfk_pkg::FC_UNDERVOLT)
		else $error("Undervoltage fault code wrong");
	AST_STARRED_HOLD: assert property (
		drive_config_word_three == dfk_pkg::CFG_HW_RESET_ONLY && calm
			&& error_code_parameter == dfk_pkg::FC_OVERSPEED
			|=> error_code_parameter == dfk_pkg::FC_OVERSPEED)
		else $error("Starred fault left without reset");
	AST_CLEAR: assert property (
		clear_fault_command && !overspeed && drive_config_word_three != 8'h10
			&& error_code_parameter == dfk_pkg::FC_OVERSPEED
			|=> error_code_parameter != dfk_pkg::FC_OVERSPEED)
		else $error("Clear command ignored");
	AST_CMD_ACCEPT: assert property (
		cmd_accept == hit_q)
		else $error("Command accept wrong");
	AST_ENTER: assert property (
		s_chord |-> ##[1:3] edit_enter)
		else $error("Enter pulse missing");
	AST_MENU_SELECT: assert property (
		s_aux_up |=> advanced_menu == $past(key_up))
		else $error("Menu choice wrong at power-up");
endmodule : dfk_assertions
bind dfk_supervisor dfk_assertions chk_i (.*);
`default_nettype wire

// ==== verification/dfk_panel_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dfk_panel_model (
	input wire logic clock, // System clock
	output logic key_up, // Right key
	output logic key_down, // Left key
	output logic clear_fault_command // Host clear
);
	// ----------------
	// Keypad and host
	// ----------------
	initial
	begin
		{key_up, key_down, clear_fault_command} = 3'h0;
	end
	task automatic keys(input logic up, input logic down);
		@(posedge clock);
		#5;
		{key_up, key_down} = {up, down};
	endtask : keys
	// One key pressed for hold cycles, then released for gap cycles
	task automatic tap(input logic up, input int hold, input int gap);
		keys(up, !up);
		repeat (hold) @(posedge clock);
		keys(1'b0, 1'b0);
		repeat (gap) @(posedge clock);
		#5;
	endtask : tap
	task automatic clear;
		@(posedge clock);
		#5;
		clear_fault_command = 1'b1;
		@(posedge clock);
		#5;
		clear_fault_command = 1'b0;
	endtask : clear
endmodule : dfk_panel_model
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clock, nrst, safe_torque_off_enable, hw_enable, warning_active, escalate_warnings;
	logic can_bus_off, overspeed, adc_error, homing_active, limit_switch_error, got;
	logic clear_fault_command, key_up, key_down, aux_supply_ok, jog_mode, menu_step;
	logic edit_load_strobe, edit_is_baud, cmd_strobe, edit_enter, cmd_accept, jog_run;
	logic [7:0] heat_sink_temp, drive_config_word_three, edit_load, cmd_station;
	logic [7:0] edit_value, station_address;
	logic [9:0] dc_bus_volts;
	logic [2:0] mains_phase_ok;
	logic [5:0] warning_code, display_code, error_code_parameter;
	logic [1:0] display_mode;
	logic ready_to_operate_contact, output_stage_on, brake_released, advanced_menu, jog_dir_up;
	logic [10:0] baud_kbps;
	logic [5:0] fcode [9] = '{6'h01, 6'h05, 6'h10, 6'h18, 6'h17, 6'h08, 6'h11, 6'h1A, 6'h1B};
	int n_fail, n_compared, cyc, n_steps;
	dfk_supervisor #(.TAP_CYCLES(8)) uut (.*);
	dfk_panel_model panel (.clock, .key_up, .key_down, .clear_fault_command);
	// ----------------
	// Helpers
	// ----------------
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#5;
	endtask : step
	task automatic chk(input logic [18:0] g, input logic [18:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic final_report;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	task automatic do_reset;
		{nrst, aux_supply_ok} = 2'h1;
		step(2);
		chk({station_address, baud_kbps}, {8'h01, 11'h3E8});
		nrst = 1'b1;
		step(2);
		chk({display_mode, error_code_parameter}, {2'h3, 6'h00});
	endtask : do_reset
	task automatic set_fault(input int i, input logic on);
		case (i)
			0: heat_sink_temp = on ? 8'h51 : 8'h50;
			1: dc_bus_volts = on ? 10'h063 : 10'h064;
			2: mains_phase_ok = on ? 3'h1 : 3'h7;
			3: {warning_active, escalate_warnings} = {on, on};
			4: can_bus_off = on;
			5: overspeed = on;
			6: adc_error = on;
			7: {homing_active, limit_switch_error} = {on, on};
			default: {safe_torque_off_enable, hw_enable} = {on, on};
		endcase
	endtask : set_fault
	task automatic load(input logic [7:0] v);
		{edit_load, edit_load_strobe} = {v, 1'b1};
		step(1);
		edit_load_strobe = 1'b0;
		step(12);
	endtask : load
	// Right key pressed first, then left: the right press itself adds one
	task automatic enter;
		panel.keys(1'b1, 1'b0);
		step(2);
		panel.keys(1'b1, 1'b1);
		got = 1'b0;
		repeat (6)
		begin
			step(1);
			got |= edit_enter;
		end
		chk(got, 1'b1);
		panel.keys(1'b0, 1'b0);
		step(12);
	endtask : enter
	task automatic aux_cycle;
		aux_supply_ok = 1'b0;
		step(2);
		aux_supply_ok = 1'b1;
		step(2);
	endtask : aux_cycle
	task automatic cmd_try(input logic [7:0] st, input logic e);
		{cmd_station, cmd_strobe} = {st, 1'b1};
		step(1);
		got = cmd_accept;
		cmd_strobe = 1'b0;
		step(1);
		chk(got, e);
	endtask : cmd_try
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_faults;
		for (int i = 0; i < 9; i++)
		begin
			set_fault(i, 1'b1);
			step(1);
			set_fault(i, 1'b0);
			step(2);
			chk(error_code_parameter, fcode[i]);
			chk(display_code, fcode[i]);
			chk({display_mode, ready_to_operate_contact, output_stage_on, brake_released}, 5'h08);
			panel.clear();
			step(1);
			chk(error_code_parameter, 6'h00);
		end
	endtask : t_faults
	task automatic t_clear;
		{drive_config_word_three, overspeed} = {8'h10, 1'b1};
		step(1);
		overspeed = 1'b0;
		panel.clear();
		step(2);
		chk(error_code_parameter, 6'h08);
		do_reset();
		heat_sink_temp = 8'h51;
		step(1);
		heat_sink_temp = 8'h50;
		panel.clear();
		step(1);
		chk(error_code_parameter, 6'h00);
		drive_config_word_three = 8'h00;
	endtask : t_clear
	task automatic t_warn_jog;
		safe_torque_off_enable = 1'b1;
		step(1);
		{hw_enable, warning_active, warning_code} = {2'h3, 6'h05};
		step(2);
		chk({display_mode, display_code, ready_to_operate_contact}, {2'h2, 6'h05, 1'b1});
		chk({output_stage_on, brake_released}, 2'h3);
		{warning_active, jog_mode} = 2'h1;
		panel.keys(1'b1, 1'b0);
		step(2);
		chk({jog_run, jog_dir_up}, 2'h3);
		panel.keys(1'b0, 1'b0);
		step(2);
		chk(jog_run, 1'b0);
		{safe_torque_off_enable, hw_enable, jog_mode} = 3'h0;
	endtask : t_warn_jog
	task automatic t_keys;
		int s;
		load(8'h32);
		s = n_steps;
		panel.tap(1'b1, 2, 12);
		chk(edit_value, 8'h33);
		chk(19'(n_steps - s), 19'h00001);
		panel.tap(1'b0, 3, 12);
		chk(edit_value, 8'h32);
		chk(19'(n_steps - s), 19'h00001);
		panel.tap(1'b1, 1, 2);
		panel.tap(1'b1, 1, 12);
		chk(edit_value, 8'h3C);
		panel.tap(1'b0, 1, 2);
		panel.tap(1'b0, 1, 12);
		chk(edit_value, 8'h32);
		enter();
		chk(station_address, 8'h01);
		panel.keys(1'b1, 1'b0);
		aux_cycle();
		chk({advanced_menu, station_address}, {1'b1, 8'h33});
		panel.keys(1'b0, 1'b0);
		aux_cycle();
		chk(advanced_menu, 1'b0);
	endtask : t_keys
	task automatic t_baud;
		logic [7:0] bl [3] = '{8'h0B, 8'h02, 8'h41};
		logic [10:0] bk [3] = '{11'h07D, 11'h07D, 11'h29A};
		edit_is_baud = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			load(bl[i]);
			enter();
			aux_cycle();
			chk(baud_kbps, bk[i]);
		end
		edit_is_baud = 1'b0;
	endtask : t_baud
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock)
	begin
		if (menu_step === 1'b1)
			n_steps++;
		cyc++;
		if (cyc == 4000)
		begin
			n_fail++;
			final_report();
		end
	end
	initial
	begin
		{nrst, hw_enable, safe_torque_off_enable, warning_active, escalate_warnings} = '0;
		{can_bus_off, overspeed, adc_error, homing_active, limit_switch_error} = '0;
		{jog_mode, edit_load_strobe, edit_is_baud, cmd_strobe, aux_supply_ok} = '0;
		{heat_sink_temp, dc_bus_volts, mains_phase_ok} = {8'h50, 10'h064, 3'h7};
		{drive_config_word_three, edit_load, cmd_station, warning_code} = '0;
		{n_fail, n_compared, cyc, n_steps} = '0;
		do_reset();
		t_faults();
		t_clear();
		t_warn_jog();
		t_keys();
		t_baud();
		cmd_try(8'h33, 1'b1);
		cmd_try(8'h34, 1'b0);
		final_report();
	end
endmodule : tb
`default_nettype wire
